// ---- dv/rtp_reload_timer_pwm_checker.sv ----
`timescale 1ns/1ps
module rtp_reload_timer_pwm_checker (
  input wire       clock, reset, counter_enable, external_clock_select, counter_access_write,
  input wire       overflow_irq_enable, overflow_flag_clear, overflow_flag, overflow_irq, pwm_out_0,
  input wire [2:0] prescale_ratio,
  input wire [7:0] auto_reload_value, counter_access_value, counter,
  input wire [31:0] duty_compare_value,
  input wire [3:0] polarity, channel_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire run = counter_enable & !counter_access_write & !external_clock_select & (prescale_ratio == 3'h0);
  a_load_now: assert property (counter_access_write |=> counter == $past(counter_access_value)) else $error("load");
  a_stop_hold: assert property (!counter_enable && !counter_access_write |=> $stable(counter)) else $error("hold");
  a_step_one: assert property (run && counter != 8'hff |=> counter == $past(counter) + 8'h01) else $error("step");
  a_reload_ovf: assert property (run && counter == 8'hff |=> counter == $past(auto_reload_value) && overflow_flag)
    else $error("reload");
  a_flag_hold: assert property (overflow_flag && !overflow_flag_clear |=> overflow_flag) else $error("flag");
  a_flag_clear: assert property (overflow_flag_clear && counter != 8'hff |=> !overflow_flag) else $error("clr");
  a_irq_gate: assert property (overflow_irq |-> $past(overflow_irq_enable) && overflow_flag) else $error("irq");
  a_pwm_level: assert property (!$past(reset) |-> pwm_out_0 ==
    $past(channel_enable[0] & (polarity[0] ^ (counter <= duty_compare_value[7:0])))) else $error("pwm");
  cover property (run && counter == 8'hff);
  cover property (overflow_irq);
  cover property (pwm_out_0 && polarity[0]);
endmodule

// ---- dv/rtp_reload_timer_pwm_test.sv ----
`timescale 1ns/1ps
`define CHK(n,e,s) begin cmp_count++; if ((e)!==(s)) begin errors++; $display("ERROR %s exp %h got %h",n,e,s); end end
module rtp_reload_timer_pwm_test;
  reg clock=0, reset=1, counter_enable=0, overflow_irq_enable=0, counter_access_write=0, overflow_flag_clear=0;
  reg [2:0] prescale_ratio=0;
  reg [7:0] auto_reload_value=0, counter_access_value=0, mc=0;
  reg [31:0] duty_compare_value=0;
  reg [3:0] polarity=0, channel_enable=0, mp=0;
  reg mf=0, mi=0, ml=0, tick=0, ext_sel=0, ext_pin=0;
  reg [2:0] ms=0;
  wire [7:0] counter;
  wire overflow_flag, overflow_irq, pwm_out_0, pwm_out_1, pwm_out_2, pwm_out_3;
  integer errors=0, cmp_count=0, cyc=0, ps=0, t, k, i;
  always #12.5 clock = ~clock;
  rtp_reload_timer_pwm i_rtp_reload_timer_pwm (.*, .external_clock_select(ext_sel), .ext_clock_pin(ext_pin));
  // reference model of counter, prescaler, flag and outputs
  always @(posedge clock or posedge reset) begin
    if (reset) {mc, ps, mf, mi, mp, ms, ml} = 0;
    else begin
      tick = !ext_sel || ((ms[1] == ms[2]) && ms[2] && !ml);
      if (ms[1] == ms[2]) ml = ms[2];
      ms = {ms[1:0], ext_pin};
      for (i = 0; i < 4; i++) mp[i] = channel_enable[i] & (polarity[i] ^ (mc <= duty_compare_value[8*i+:8]));
      if (overflow_flag_clear) mf = 0;
      if (counter_access_write) {mc, ps} = {counter_access_value, 32'h0};
      else if (counter_enable && tick && ps == (1 << prescale_ratio) - 1) begin
        ps = 0;
        if (mc == 8'hff) {mc, mf} = {auto_reload_value, 1'b1};
        else mc = mc + 8'h01;
      end else if (counter_enable && tick) ps = ps + 1;
      mi = overflow_irq_enable & mf;
    end
  end
  always @(posedge clock) if (++cyc == 5000) begin errors++; end_of_test; end
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h92c4));
    repeat (2) @(negedge clock);
    reset = 0;
    for (t = 0; t < 9; t++) begin
      for (k = 0; k < 400; k++) begin
        @(negedge clock);
        `CHK("counter", mc, counter)
        `CHK("flag", mf, overflow_flag)
        `CHK("irq", mi, overflow_irq)
        `CHK("pwm", mp, {pwm_out_3, pwm_out_2, pwm_out_1, pwm_out_0})
        counter_access_write = k == 0 || (t == 0 && $urandom % 20 == 0);
        if (counter_access_write) {prescale_ratio, ext_sel} = {t[2:0], t == 8};
        ext_pin = k[1];
        counter_access_value = k == 0 ? 8'hfd : $urandom;
        auto_reload_value = $urandom;
        overflow_irq_enable = $urandom;
        overflow_flag_clear = $urandom % 9 == 0;
        counter_enable = t > 0 || $urandom % 4 > 0;
        if (k % 32 == 0) {duty_compare_value, polarity, channel_enable} = {$urandom, $urandom};
      end
      $display("test %0d done", t);
    end
    end_of_test;
  end
endmodule
bind rtp_reload_timer_pwm rtp_reload_timer_pwm_checker i_rtp_reload_timer_pwm_checker (.*);

// ---- verilog/rtp_map.vh ----
`ifndef RTP_MAP_VH
`define RTP_MAP_VH
`define RTP_CNT_W        8
`define RTP_CHANNELS     4
`define RTP_PS_W         3
`define RTP_PS_CNT_W     7
`define RTP_CNT_RESET    8'h00
`define RTP_ARR_RESET    8'h00
`define RTP_PS_RESET     7'h00
`define RTP_CNT_MAX      8'hff
`define RTP_PS_LIM_1     7'h00
`define RTP_PS_LIM_2     7'h01
`define RTP_PS_LIM_4     7'h03
`define RTP_PS_LIM_8     7'h07
`define RTP_PS_LIM_16    7'h0f
`define RTP_PS_LIM_32    7'h1f
`define RTP_PS_LIM_64    7'h3f
`define RTP_PS_LIM_128   7'h7f
`endif

// ---- verilog/rtp_reload_timer_pwm.v ----
// Contract
// - on overflow reload counter from auto-reload value and clear prescaler count.
// - counter access write loads counter immediately, also clears prescaler count.
// - auto-reload and counter access values are 8 bits, full range.
// - counter clock is input clock divided by 1,2,4,...,128.
// - input clock is cpu clock unless external clock selected.
// - four compare channels, each compares its value against the counter.
// - polarity 0: low when counter above compare, else high.
// - polarity 1: high when counter above compare, else low.
// - each channel holds an 8-bit full-range duty compare value.
// - each enabled channel drives its own pwm output pin.
// - after reset cpu clock, counter stopped, interrupt disabled, control zero.
// - a control bit enables the overflow interrupt request.
`timescale 1ns/1ps
`include "rtp_map.vh"
module rtp_reload_timer_pwm #(
  parameter CNT_W = `RTP_CNT_W,
  parameter NCH   = `RTP_CHANNELS
) (
  input  wire               clock,                 // 40 mhz cpu clock
  input  wire               reset,                 // async, active high
  input  wire               counter_enable,        // counter runs while high
  input  wire               external_clock_select, // 1: count external clock rising edges
  input  wire               ext_clock_pin,         // external clock input pin
  input  wire [2:0]         prescale_ratio,        // divide by 2**ratio
  input  wire               overflow_irq_enable,   // overflow interrupt enable
  input  wire [CNT_W-1:0]   auto_reload_value,     // reload value on overflow
  input  wire [CNT_W-1:0]   counter_access_value,  // value for direct load
  input  wire               counter_access_write,  // one-cycle load strobe
  input  wire [NCH*CNT_W-1:0] duty_compare_value,  // per-channel compare values
  input  wire [NCH-1:0]     polarity,              // per-channel polarity
  input  wire [NCH-1:0]     channel_enable,        // per-channel output enable
  input  wire               overflow_flag_clear,   // one-cycle clear of flag
  output reg  [CNT_W-1:0]   counter,               // running counter value
  output reg                overflow_flag,         // sticky overflow flag
  output reg                overflow_irq,          // interrupt request level
  output reg                pwm_out_0,             // channel 0 pin
  output reg                pwm_out_1,             // channel 1 pin
  output reg                pwm_out_2,             // channel 2 pin
  output reg                pwm_out_3              // channel 3 pin
);

  localparam PS_W = `RTP_PS_CNT_W;

  // external clock synchroniser
  reg                       ext_stage_1;
  reg                       ext_stage_2;
  reg                       ext_stage_3;
  reg                       ext_level;
  wire                      ext_agree;
  wire                      ext_rise;

  // prescaler
  reg  [PS_W-1:0]           ps_count;
  reg  [PS_W-1:0]           next_ps_count;
  reg  [PS_W-1:0]           ps_limit;
  wire                      in_tick;
  wire                      ps_wrap;

  // counter
  reg  [CNT_W-1:0]          next_counter;
  wire                      cnt_tick;
  wire                      at_max;
  wire                      overflow_evt;

  // overflow flag and interrupt
  reg                       next_overflow_flag;
  reg                       next_overflow_irq;

  // compare channels
  wire [NCH-1:0]            above;
  wire [NCH-1:0]            next_pwm;

  // three stages on the asynchronous pin
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_stage_1 <= 1'b0;
      ext_stage_2 <= 1'b0;
      ext_stage_3 <= 1'b0;
    end else begin
      ext_stage_1 <= ext_clock_pin;
      ext_stage_2 <= ext_stage_1;
      ext_stage_3 <= ext_stage_2;
    end
  end

  // a level counts only once stages 2 and 3 agree
  assign ext_agree = (ext_stage_2 == ext_stage_3);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_level <= 1'b0;
    end else if (ext_agree) begin
      ext_level <= ext_stage_3;
    end
  end

  assign ext_rise = ext_agree && ext_stage_3 && !ext_level;

  // last prescaler count before a counter tick
  always @* begin
    case (prescale_ratio)
      3'h0: begin
        ps_limit = `RTP_PS_LIM_1;
      end
      3'h1: begin
        ps_limit = `RTP_PS_LIM_2;
      end
      3'h2: begin
        ps_limit = `RTP_PS_LIM_4;
      end
      3'h3: begin
        ps_limit = `RTP_PS_LIM_8;
      end
      3'h4: begin
        ps_limit = `RTP_PS_LIM_16;
      end
      3'h5: begin
        ps_limit = `RTP_PS_LIM_32;
      end
      3'h6: begin
        ps_limit = `RTP_PS_LIM_64;
      end
      3'h7: begin
        ps_limit = `RTP_PS_LIM_128;
      end
      default: begin
        ps_limit = `RTP_PS_LIM_1;
      end
    endcase
  end

  assign in_tick      = external_clock_select ? ext_rise : 1'b1;
  assign ps_wrap      = (ps_count == ps_limit);
  assign cnt_tick     = counter_enable && in_tick && ps_wrap;
  assign at_max       = (counter == `RTP_CNT_MAX);
  // a direct load takes priority, so no overflow is reported with it
  assign overflow_evt = cnt_tick && at_max && !counter_access_write;

  always @* begin
    next_counter  = counter;
    next_ps_count = ps_count;
    if (counter_access_write) begin
      next_counter  = counter_access_value;
      next_ps_count = `RTP_PS_RESET;
    end else if (cnt_tick) begin
      next_ps_count = `RTP_PS_RESET;
      if (at_max) begin
        next_counter = auto_reload_value;
      end else begin
        next_counter = counter + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else if (counter_enable && in_tick) begin
      next_ps_count = ps_count + {{(PS_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      counter  <= `RTP_CNT_RESET;
      ps_count <= `RTP_PS_RESET;
    end else begin
      counter  <= next_counter;
      ps_count <= next_ps_count;
    end
  end

  // set wins over clear
  always @* begin
    next_overflow_flag = overflow_flag;
    if (overflow_evt) begin
      next_overflow_flag = 1'b1;
    end else if (overflow_flag_clear) begin
      next_overflow_flag = 1'b0;
    end
    next_overflow_irq = overflow_irq_enable && next_overflow_flag;
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      overflow_flag <= 1'b0;
      overflow_irq  <= 1'b0;
    end else begin
      overflow_flag <= next_overflow_flag;
      overflow_irq  <= next_overflow_irq;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      assign above[ch]    = counter > duty_compare_value[ch*CNT_W +: CNT_W];
      assign next_pwm[ch] = channel_enable[ch] ? (polarity[ch] ? above[ch] : !above[ch]) : 1'b0;
    end
  endgenerate

  // one register per pin
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pwm_out_0 <= 1'b0;
    end else begin
      pwm_out_0 <= next_pwm[0];
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pwm_out_1 <= 1'b0;
    end else begin
      pwm_out_1 <= next_pwm[1];
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pwm_out_2 <= 1'b0;
    end else begin
      pwm_out_2 <= next_pwm[2];
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pwm_out_3 <= 1'b0;
    end else begin
      pwm_out_3 <= next_pwm[3];
    end
  end

endmodule
